// File: core/eco_consts.svh
`ifndef ECO_CONSTS_SVH
`define ECO_CONSTS_SVH

// =============================================================
// Register word indices (Avalon word address)
`define ECO_REG_CONFIG      3'h0
`define ECO_REG_WINDOW      3'h1
`define ECO_REG_MODE        3'h2
`define ECO_REG_WARN        3'h3
`define ECO_REG_STATUS      3'h4

// =============================================================
// Field positions
`define ECO_GRAN_LSB        0
`define ECO_WFE_BIT         12
`define ECO_ESI_LSB         16
`define ECO_WIN_LSB         12
`define ECO_REV_BIT         0
`define ECO_FLIP_BIT        1
`define ECO_IWS_LSB         4
`define ECO_WARN_BIT        0

// =============================================================
// Reset values
`define ECO_GRAN_RST        4'h3
`define ECO_ESI_RST         6'h08
`define ECO_WIN_RST         6'h00
`define ECO_IWS_RST         2'h0

// =============================================================
// Timing: edge step unit 0.125 us, clock period 40 ns
`define ECO_STEP_UNIT_NS    16'h007d
`define ECO_CLK_PERIOD_NS   16'h0028

`endif

// File: core/eco_pkg.sv
package eco_pkg;

	typedef logic [13:0] eco_angle_type;
	typedef logic [2:0]  eco_sector_type;

	typedef enum logic [1:0] {
		ECO_DIR_NONE,
		ECO_DIR_FWD,
		ECO_DIR_BACK
	} eco_dir_type;

endpackage

// File: core/eco_uvw_phase.sv
`timescale 1ns/1ps
`default_nettype none

module eco_uvw_phase #(
	parameter logic [2:0] OFFSET = 3'h0
) (
	input  wire logic [2:0] sector, // Electrical sector 0..5
	output logic            phaseHigh // Phase level, uninverted
);
	logic [2:0] rel;

	// Phase is high for three of six sectors, shifted by OFFSET
	always_comb begin
		if (sector >= OFFSET) begin
			rel = sector - OFFSET;
		end else begin
			rel = sector + 3'h6 - OFFSET;
		end
		phaseHigh = (rel < 3'h3);
	end

endmodule

`default_nettype wire

// File: core/eco_output_core.sv
// Contract
// - Index pulse width selectable among four options
// - Increasing angle: zero at index rising edge
// - Decreasing angle: zero at index falling edge
// - Index width from granularity and width select
// - Rate limiting only when step interval nonzero
// - Skipped states stepped out at programmed interval
// - Samples nominally 1 us; interval may exceed
// - Limited outputs still track true position
// - Warning flag set whenever limiting occurs
// - Interval field bits 21:16, (k+1)*0.125 us
// - Granularity field bits 3:0 of config
// - Reversal with filter back-fills at limited rate
// - Window filter enable selects filtered angle
// - Commutation outputs switch at transition angles
// - One pair: 180 degree high, 120 apart
// - Granularity n gives n+1 pole pairs
// - Quadrature order 00,01,11,10 by direction
// - Polarity flip inverts all six outputs
// - Granularity 3..14 gives 2048 down to 1
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "eco_consts.svh"

module eco_output_core (
	input  wire logic                  sys_clk,         // 25 MHz clock
	input  wire logic                  sys_rst,         // Async reset
	input  wire logic [2:0]            avsAddress,      // Word address
	input  wire logic                  avsRead,         // Read request
	input  wire logic                  avsWrite,        // Write request
	input  wire logic [31:0]           avsWriteData,    // Write data
	input  wire logic [3:0]            avsByteEnable,   // Byte lanes
	output logic      [31:0]           avsReadData,     // Read data
	output logic                       avsWaitRequest,  // Bus stall
	input  wire eco_pkg::eco_angle_type angleSample,    // Raw angle
	input  wire eco_pkg::eco_angle_type hystAngleSample, // Filtered angle
	input  wire logic                  sampleValid,     // Sample strobe
	output logic                       encA,            // Quadrature A
	output logic                       encB,            // Quadrature B
	output logic                       encIndex,        // Index pulse
	output logic                       commU,           // Phase U
	output logic                       commV,           // Phase V
	output logic                       commW            // Phase W
);
	import eco_pkg::*;

	// =========================================================
	// Configuration state
	logic [3:0]    granularity;
	logic          windowFilterEnable;
	logic [5:0]    edgeStepInterval;
	logic [5:0]    hystWindow;
	logic          rotationReverse;
	logic          outputPolarityFlip;
	logic [1:0]    indexWidthSel;
	logic          stepLimitWarning;

	// =========================================================
	// Datapath signals
	eco_angle_type  angleReg;
	eco_angle_type  angleSel;
	logic [13:0]    qOut;
	logic [13:0]    qTarget;
	logic [13:0]    qMask;
	logic [13:0]    qDiff;
	logic [3:0]     qShift;
	logic [7:0]     stepTimer;
	logic [7:0]     stepCycles;
	logic [15:0]    stepNs;
	logic           limitOn;
	logic           stepAllowed;
	logic           dirFwd;
	logic           dirBack;
	logic           stepFwd;
	logic           stepBack;
	logic           stepNow;
	logic           limitEvent;
	logic [1:0]     abRaw;
	logic [2:0]     idxWidth;
	logic           indexRaw;
	eco_dir_type    lastDir;
	logic [4:0]     polePairs;
	logic [18:0]    elecProd;
	logic [16:0]    sectorProd;
	eco_sector_type sector;
	logic           uRaw;
	logic           vRaw;
	logic           wRaw;
	logic           busWrite;
	logic           warnClear;

	// =========================================================
	// Avalon slave: one wait cycle, then one answer cycle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avsWaitRequest <= 1'b1;
		end else if (avsWaitRequest && (avsRead || avsWrite)) begin
			avsWaitRequest <= 1'b0;
		end else begin
			avsWaitRequest <= 1'b1;
		end
	end

	assign busWrite  = avsWrite && !avsWaitRequest;
	assign warnClear = busWrite && (avsAddress == `ECO_REG_WARN) &&
		avsByteEnable[0] && avsWriteData[`ECO_WARN_BIT];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avsReadData <= 32'h0;
		end else if (avsRead && avsWaitRequest) begin
			unique case (avsAddress)
				`ECO_REG_CONFIG: avsReadData <= {10'h0, edgeStepInterval,
					3'h0, windowFilterEnable, 8'h0, granularity};
				`ECO_REG_WINDOW: avsReadData <= {14'h0, hystWindow, 12'h0};
				`ECO_REG_MODE:   avsReadData <= {26'h0, indexWidthSel, 2'h0,
					outputPolarityFlip, rotationReverse};
				`ECO_REG_WARN:   avsReadData <= {31'h0, stepLimitWarning};
				`ECO_REG_STATUS: avsReadData <= {3'h0, qOut[12:0], 6'h0,
					lastDir, 2'h0, wRaw, vRaw, uRaw, indexRaw, abRaw[0],
					abRaw[1]};
				default:         avsReadData <= 32'h0;
			endcase
		end
	end

	// Config word writes by byte lane
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			granularity        <= `ECO_GRAN_RST;
			windowFilterEnable <= 1'b0;
			edgeStepInterval   <= `ECO_ESI_RST;
		end else if (busWrite && avsAddress == `ECO_REG_CONFIG) begin
			if (avsByteEnable[0]) begin
				granularity <= avsWriteData[`ECO_GRAN_LSB +: 4];
			end
			if (avsByteEnable[1]) begin
				windowFilterEnable <= avsWriteData[`ECO_WFE_BIT];
			end
			if (avsByteEnable[2]) begin
				edgeStepInterval <= avsWriteData[`ECO_ESI_LSB +: 6];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hystWindow <= `ECO_WIN_RST;
		end else if (busWrite && avsAddress == `ECO_REG_WINDOW) begin
			if (avsByteEnable[1]) begin
				hystWindow[3:0] <= avsWriteData[`ECO_WIN_LSB +: 4];
			end
			if (avsByteEnable[2]) begin
				hystWindow[5:4] <= avsWriteData[`ECO_WIN_LSB + 4 +: 2];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rotationReverse    <= 1'b0;
			outputPolarityFlip <= 1'b0;
			indexWidthSel      <= `ECO_IWS_RST;
		end else if (busWrite && avsAddress == `ECO_REG_MODE &&
				avsByteEnable[0]) begin
			rotationReverse    <= avsWriteData[`ECO_REV_BIT];
			outputPolarityFlip <= avsWriteData[`ECO_FLIP_BIT];
			indexWidthSel      <= avsWriteData[`ECO_IWS_LSB +: 2];
		end
	end

	// Sticky warning: a new event wins over a same-cycle clear
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stepLimitWarning <= 1'b0;
		end else if (limitEvent) begin
			stepLimitWarning <= 1'b1;
		end else if (warnClear) begin
			stepLimitWarning <= 1'b0;
		end
	end

	// =========================================================
	// Angle capture, filter select and direction reverse
	assign angleSel = windowFilterEnable ? hystAngleSample
		: angleSample;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			angleReg <= 14'h0;
		end else if (sampleValid) begin
			angleReg <= rotationReverse ? (14'h0 - angleSel)
				: angleSel;
		end
	end

	// =========================================================
	// Quadrature position from granularity
	always_comb begin
		if (granularity < 4'h3) begin
			qShift = 4'h1;
		end else if (granularity == 4'hf) begin
			qShift = 4'hc;
		end else begin
			qShift = granularity - 4'h2;
		end
	end

	assign qMask   = 14'h3fff >> qShift;
	assign qTarget = angleReg >> qShift;
	assign qDiff   = (qTarget - qOut) & qMask;
	assign dirFwd  = (qDiff != 14'h0) && (qDiff <= (qMask >> 1));
	assign dirBack = (qDiff != 14'h0) && !dirFwd;

	// =========================================================
	// Edge step limiter
	assign stepNs = ({10'h0, edgeStepInterval} + 16'h1) *
		`ECO_STEP_UNIT_NS;
	assign stepCycles = 8'((stepNs + `ECO_CLK_PERIOD_NS - 16'h1) /
		`ECO_CLK_PERIOD_NS);
	assign limitOn     = (edgeStepInterval != 6'h0);
	assign stepAllowed = !limitOn || (stepTimer == 8'h0);
	assign stepFwd     = dirFwd && stepAllowed;
	assign stepBack    = dirBack && stepAllowed;
	assign stepNow     = stepFwd || stepBack;
	// Limiting takes place on a skipped state or a held step
	assign limitEvent  = limitOn && (dirFwd || dirBack) &&
		(!stepAllowed || (dirFwd && qDiff != 14'h1) ||
		(dirBack && qDiff != qMask));

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stepTimer <= 8'h0;
		end else if (!limitOn) begin
			stepTimer <= 8'h0;
		end else if (stepNow) begin
			stepTimer <= stepCycles - 8'h1;
		end else if (stepTimer != 8'h0) begin
			stepTimer <= stepTimer - 8'h1;
		end
	end

	// Output position walks toward the target; a filtered
	// reversal jump is back-filled here at the limited rate
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			qOut <= 14'h0;
		end else if (stepFwd) begin
			qOut <= (qOut + 14'h1) & qMask;
		end else if (stepBack) begin
			qOut <= (qOut - 14'h1) & qMask;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lastDir <= ECO_DIR_NONE;
		end else if (stepFwd) begin
			lastDir <= ECO_DIR_FWD;
		end else if (stepBack) begin
			lastDir <= ECO_DIR_BACK;
		end
	end

	assign abRaw    = {qOut[1], qOut[1] ^ qOut[0]};
	// Index high on the first states after zero: rising edge at
	// zero going up, falling edge at zero going down
	assign idxWidth = {1'b0, indexWidthSel} + 3'h1;
	assign indexRaw = (qOut < {11'h0, idxWidth});

	// =========================================================
	// Commutation phases
	assign polePairs  = {1'b0, granularity} + 5'h1;
	assign elecProd   = angleReg * polePairs;
	assign sectorProd = {3'h0, elecProd[13:0]} * 17'h6;
	assign sector     = sectorProd[16:14];

	eco_uvw_phase #(.OFFSET(3'h0)) uPhase (
		.sector    (sector),
		.phaseHigh (uRaw)
	);
	eco_uvw_phase #(.OFFSET(3'h2)) vPhase (
		.sector    (sector),
		.phaseHigh (vRaw)
	);
	eco_uvw_phase #(.OFFSET(3'h4)) wPhase (
		.sector    (sector),
		.phaseHigh (wRaw)
	);

	// =========================================================
	// Output flip-flops with polarity flip
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			encA     <= 1'b0;
			encB     <= 1'b0;
			encIndex <= 1'b1;
			commU    <= 1'b1;
			commV    <= 1'b0;
			commW    <= 1'b1;
		end else begin
			encA     <= abRaw[1] ^ outputPolarityFlip;
			encB     <= abRaw[0] ^ outputPolarityFlip;
			encIndex <= indexRaw ^ outputPolarityFlip;
			commU    <= uRaw ^ outputPolarityFlip;
			commV    <= vRaw ^ outputPolarityFlip;
			commW    <= wRaw ^ outputPolarityFlip;
		end
	end

	// =========================================================
	// Assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence seq_busRequest;
		(avsRead || avsWrite) && avsWaitRequest;
	endsequence

	sequence seq_limitedStep;
		limitOn && stepNow;
	endsequence

	bus_answer_a: assert property (seq_busRequest |=> !avsWaitRequest)
		else $error("Bus request not answered after one wait cycle");

	single_step_a: assert property (
		$countones(abRaw ^ $past(abRaw)) <= 1)
		else $error("Both quadrature signals changed together");

	limit_off_a: assert property (
		!limitOn && (dirFwd || dirBack) |=> qOut != $past(qOut))
		else $error("Unlimited step did not advance");

	step_gap_a: assert property (
		seq_limitedStep |=> (!stepNow || !limitOn) [*6])
		else $error("Limited steps closer than minimum interval");

	warn_set_a: assert property (
		limitOn && dirFwd && !stepAllowed |=> stepLimitWarning)
		else $error("Warning flag missed a held step");

	index_rise_a: assert property (
		stepFwd && qOut == qMask && idxWidth <= qMask[2:0] |=>
		indexRaw && !$past(indexRaw))
		else $error("Index did not rise at zero going up");

	index_fall_a: assert property (
		stepBack && qOut == 14'h0 && idxWidth <= qMask[2:0] |=>
		!indexRaw && $past(indexRaw))
		else $error("Index did not fall at zero going down");

	polarity_out_a: assert property (
		##1 encA == ($past(abRaw[1]) ^ $past(outputPolarityFlip)))
		else $error("Output A polarity wrong");

	phase_spread_a: assert property (
		!(commU == commV && commV == commW))
		else $error("All commutation phases equal");

endmodule

`default_nettype wire

// File: verif/eco_receiver_model.sv
`timescale 1ns/1ps
`default_nettype none

module eco_receiver_model #(
	parameter int SETTLE_CYCLES = 4
) (
	input  wire logic        sys_clk,    // Clock
	input  wire logic        sys_rst,    // Async reset
	input  wire logic        encA,       // Quadrature A
	input  wire logic        encB,       // Quadrature B
	input  wire logic        clearStats, // Restart gap tally
	output logic      [15:0] count,      // Decoded position
	output logic      [15:0] minGap,     // Shortest edge spacing
	output logic      [7:0]  badSteps    // Two-signal jumps
);
	logic [7:0]  settle;
	logic [15:0] gap;
	logic [1:0]  prevState;
	logic [1:0]  curState;
	logic [1:0]  diff;

	assign curState = {encA, encA ^ encB};
	assign diff     = curState - prevState;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			settle    <= 8'h00;
			count     <= 16'h0000;
			minGap    <= 16'hffff;
			badSteps  <= 8'h00;
			gap       <= 16'h0000;
			prevState <= 2'h0;
		end else if (settle < SETTLE_CYCLES) begin
			// Levels not trusted yet
			settle    <= settle + 8'h01;
			prevState <= curState;
		end else begin
			prevState <= curState;
			if (diff != 2'h0)
				gap <= 16'h0001;
			else if (gap != 16'hffff)
				gap <= gap + 16'h0001;
			if (diff == 2'h1)
				count <= count + 16'h0001;
			if (diff == 2'h3)
				count <= count - 16'h0001;
			if (diff == 2'h2)
				badSteps <= badSteps + 8'h01;
			if (clearStats)
				minGap <= 16'hffff;
			else if (diff != 2'h0 && gap < minGap)
				minGap <= gap;
		end
	end
endmodule

`default_nettype wire

// File: verif/encoder_commutation_output_bench.sv
`timescale 1ns/1ps
`default_nettype none

module encoder_commutation_output_bench;
	import eco_pkg::*;
	logic          sys_clk = 1'b0;
	logic          sys_rst = 1'b1;
	logic [2:0]    avsAddress = 3'h0;
	logic          avsRead = 1'b0;
	logic          avsWrite = 1'b0;
	logic [31:0]   avsWriteData = 32'h0;
	logic [3:0]    avsByteEnable = 4'hf;
	logic [31:0]   avsReadData;
	logic          avsWaitRequest;
	eco_angle_type angleSample = 14'h0000;
	eco_angle_type hystAngleSample = 14'h0000;
	logic          sampleValid = 1'b0;
	logic          encA, encB, encIndex, commU, commV, commW;
	logic          clearStats = 1'b0;
	logic [15:0]   count, minGap;
	logic [7:0]    badSteps;
	logic [31:0]   rd;
	int            n_mismatch = 0;
	int            comparisons = 0;
	int            q, g, s, k, t;

	always #20 sys_clk = ~sys_clk;

	eco_output_core u_eco_output_core (.sys_clk, .sys_rst, .avsAddress,
		.avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData,
		.avsWaitRequest, .angleSample, .hystAngleSample, .sampleValid,
		.encA, .encB, .encIndex, .commU, .commV, .commW);

	eco_receiver_model u_eco_receiver_model (.sys_clk, .sys_rst, .encA,
		.encB, .clearStats, .count, .minGap, .badSteps);

	// ==========================================
	// Tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		comparisons++;
		if (v !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, v);
		end
	endtask

	task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= ~wr;
		// Only the watchdog ends a wait that never answers
		do begin
			@(posedge sys_clk);
		end while (avsWaitRequest !== 1'b0);
		rd = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask

	task smp(input logic [13:0] a, input logic [13:0] h, input int w);
		@(posedge sys_clk);
		angleSample <= a;
		hystAngleSample <= h;
		sampleValid <= 1'b1;
		@(posedge sys_clk);
		sampleValid <= 1'b0;
		repeat (w) @(posedge sys_clk);
		#1;
	endtask

	task clr;
		@(posedge sys_clk);
		clearStats <= 1'b1;
		@(posedge sys_clk);
		clearStats <= 1'b0;
	endtask

	task qchk(input logic [12:0] p, input int w);
		chk("encA", p[1], encA);
		chk("encB", p[1] ^ p[0], encB);
		chk("encIndex", p < w, encIndex);
		chk("count", p, count[12:0]);
	endtask

	task end_of_test;
		$display("Checks %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================
	// Sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("uvwReset", 3'h5, {commU, commV, commW});
		bus(1'b0, 3'h0, 32'h0);
		chk("config", 32'h00080003, rd);
		bus(1'b1, 3'h6, 32'hffffffff);
		bus(1'b0, 3'h6, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, 3'h1, 32'h0002a000);
		bus(1'b0, 3'h1, 32'h0);
		chk("window", 32'h0002a000, rd);
		bus(1'b1, 3'h0, 32'h00000003);
		for (k = 0; k < 4; k++) begin
			bus(1'b1, 3'h2, 32'(k << 4));
			for (q = 4; q > -5; q--) begin
				smp(14'(q * 2), 14'h0000, 8);
				qchk(13'(q), k + 1);
			end
			for (q = -4; q < 5; q++) begin
				smp(14'(q * 2), 14'h0000, 8);
				qchk(13'(q), k + 1);
			end
		end
		chk("badSteps", 32'h0, badSteps);
		// Limited jump of eight states on the filtered angle
		bus(1'b1, 3'h0, 32'h00011003);
		clr;
		smp(14'h0000, 14'h0018, 100);
		qchk(13'h000c, 4);
		chk("gapLimited", 1'b1, minGap >= 16'h0007);
		bus(1'b0, 3'h3, 32'h0);
		chk("warn", 1'b1, rd[0]);
		bus(1'b0, 3'h4, 32'h0);
		chk("qOut", 32'h0c, rd[28:16]);
		chk("lastDir", 32'h1, rd[9:8]);
		chk("rawBits", 32'h28, rd[5:0]);
		smp(14'h0000, 14'h0008, 100);
		qchk(13'h0004, 4);
		bus(1'b1, 3'h3, 32'h1);
		bus(1'b0, 3'h3, 32'h0);
		chk("warnClear", 1'b0, rd[0]);
		// Limiter off
		bus(1'b1, 3'h0, 32'h00001003);
		clr;
		smp(14'h0000, 14'h0010, 20);
		qchk(13'h0008, 4);
		chk("gapFree", 32'h1, minGap);
		bus(1'b0, 3'h3, 32'h0);
		chk("warnOff", 1'b0, rd[0]);
		bus(1'b1, 3'h2, 32'h1);
		smp(14'h0000, 14'h0004, 20);
		qchk(13'h1ffe, 1);
		smp(14'h0000, 14'h0000, 8);
		qchk(13'h0000, 1);
		bus(1'b1, 3'h2, 32'h3);
		repeat (3) @(posedge sys_clk);
		#1;
		chk("flip", 6'h32, {encA, encB, encIndex, commU, commV, commW});
		bus(1'b1, 3'h2, 32'h0);
		// Granularity table, raw angle
		for (g = 3; g < 15; g++) begin
			bus(1'b1, 3'h0, 32'(g));
			smp(14'(3 << (g - 2)), 14'h0000, 8);
			chk("gran", 2'h2, {encA, encB});
			smp(14'((3 << (g - 2)) - 1), 14'h0000, 8);
			chk("gran", 2'h3, {encA, encB});
			smp(14'h0000, 14'h0000, 8);
		end
		// Commutation sectors, filtered angle differs from raw
		for (g = 0; g < 16; g++) begin
			bus(1'b1, 3'h0, 32'(g) | 32'h00001000);
			for (s = 0; s < 6; s++) begin
				t = (16384 * (2 * s + 1)) / (12 * (g + 1));
				smp(14'(t) ^ 14'h2000, 14'(t), 4);
				chk("uvw", {s <= 2, s >= 2 && s <= 4, s >= 4 || s == 0},
					{commU, commV, commW});
			end
		end
		end_of_test;
	end

	// Run needs about 2100 cycles
	initial begin
		#(40 * 30000);
		n_mismatch++;
		end_of_test;
	end
endmodule

`default_nettype wire
